// File: shared/pwr_ctl_pkg.sv
// constants for the power-down and wake controller
package pwr_ctl_pkg;
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_KEEP = 8'h08;
  localparam logic [7:0] OFS_TCTL = 8'h0C;
  localparam logic [7:0] OFS_CORE = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  // status fields
  localparam int ST_PDFLAG = 0;
  localparam int ST_SLOWREQ = 1;
  localparam int ST_CLKSLEEP = 2;
  localparam int ST_RAMSLEEP = 3;
  localparam int ST_LVACTIVE = 4;
  localparam int ST_LVARMED = 5;
  // control fields
  localparam int CT_IRQEN = 0;
  localparam int CT_WDEN = 1;
  localparam int CT_OSCSEL = 2;
  localparam int CT_PINSEL = 4;
  localparam int CT_SLOWSET = 8;
  localparam int CT_SLOWCLR = 9;
  // core context fields
  localparam int CO_ACC = 0;
  localparam int CO_REGB = 4;
  localparam int CO_CARRY = 8;
  localparam int CO_SP = 9;
  localparam int CO_PC = 16;
  // flag fields, write one to clear
  localparam int FL_EXT0 = 0;
  localparam int FL_EXT1 = 1;
  localparam int FL_CONV = 2;
  localparam int FL_SER = 3;
  localparam int FL_WD1 = 4;
  localparam int FL_WD2 = 5;
  localparam logic [2:0] SP_INIT = 3'h7;
  localparam logic [1:0] PINSEL_INPUT = 2'h3;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_KEEP = 32'h0000_0000;
  localparam logic [19:0] RST_TCTL = 20'h0_0000;
  typedef enum logic [2:0] {
    RUN = 3'b001,
    CLK_SLEEP = 3'b010,
    RAM_SLEEP = 3'b100
  } pwr_state_t;
endpackage

// File: rtl/power_down_wake_control.sv
// power-down entry, retention, wake and start-type logic with an apb register port
//
// Behaviour
// - ram backup keeps only ram and reset
// - warm start at zero, sleep flag one
// - cold start at zero, sleep flag zero
// - sleep flag and slow timer flag readable
// - entry clears pc, acc, b, carry; sp=7
// - listed control registers survive both modes
// - oscillator selection survives power-down
// - timer controls w1-w3, w5, w6 cleared on entry
// - timers one to four undefined after sleep
// - slow timer counts in clock mode, flag kept
// - entry clears serial, converter, irq flags, enable
// - entry clears watchdog and its flags
// - display on in clock mode, off in backup
// - low-voltage detect in sleep needs arm and pin
// - counter pin low, or input when select 11
// - clock mode wakes on pin or slow flag
// - ram backup wakes only on external pin
// - unlisted state reinitialised after return
// - entry only right after sleep enable instruction
`timescale 1ns/10ps
`default_nettype none
module power_down_wake_control
  import pwr_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instrDone,
  input wire logic sleep_enable_instr,
  input wire logic clock_run_sleep_instr,
  input wire logic ram_keep_sleep_instr,
  input wire logic arm_lowvolt_in_sleep,
  input wire logic extWakeup,
  input wire logic slowTimerUnderflow,
  input wire logic resetPinPulse,
  input wire logic watchdogReset,
  input wire logic lowvoltTrip,
  input wire logic lowvolt_detect_enable_pin,
  input wire logic extIrqEvent0,
  input wire logic extIrqEvent1,
  input wire logic conversionDone,
  input wire logic serialDone,
  input wire logic watchdogEvent1,
  input wire logic watchdogEvent2,
  input wire logic counterPinDrive,
  input wire logic counterPinDriveEn,
  output logic startPulse,
  output logic warmStart,
  output logic coreInit,
  output logic peripheralInit,
  output logic ramOnlyKeep,
  output logic slowTimerRun,
  output logic fastTimersRun,
  output logic displayOn,
  output logic lowvoltActive,
  output logic portHold,
  output logic shared_counter_pin_out,
  output logic shared_counter_pin_oe
);
  logic rstSync1, rstSync2;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  wire rst_n = rstSync2;

  pwr_state_t state, next_state;
  logic sleepFlag, slowReq, sleepArmed, lvArmed;
  logic [31:0] ctrl, keepRegs, core;
  logic [19:0] timerCtrl;
  logic [5:0] flags;

  // apb decode
  wire setup = psel && !penable;
  wire access = psel && penable && pready;
  wire wrHit = access && pwrite;
  wire wrCtrl = wrHit && paddr == OFS_CTRL;
  wire wrKeep = wrHit && paddr == OFS_KEEP;
  wire wrTctl = wrHit && paddr == OFS_TCTL;
  wire wrCore = wrHit && paddr == OFS_CORE;
  wire wrFlags = wrHit && paddr == OFS_FLAGS;
  wire mapped = paddr == OFS_STATUS || paddr == OFS_CTRL || paddr == OFS_KEEP
    || paddr == OFS_TCTL || paddr == OFS_CORE || paddr == OFS_FLAGS;

  // cold sources; low-voltage trip counts only while the detector is live
  wire running = state == RUN;
  wire lvLive = lowvolt_detect_enable_pin && (running || lvArmed);
  wire coldHit = resetPinPulse || watchdogReset || (lowvoltTrip && lvLive);

  // an entry instruction acts only when the enable came just before it
  wire enterClk = running && instrDone && clock_run_sleep_instr && sleepArmed;
  wire enterRam = running && instrDone && ram_keep_sleep_instr && sleepArmed;
  wire enter = enterClk || enterRam;
  wire wakeClk = state == CLK_SLEEP && (extWakeup || slowReq);
  wire wakeRam = state == RAM_SLEEP && extWakeup;
  wire wake = wakeClk || wakeRam;
  // the slow timer has no clock in ram backup, so its underflow is ignored there
  wire slowTick = slowTimerUnderflow && state != RAM_SLEEP;

  always_comb begin
    next_state = state;
    unique case (state)
      RUN: begin
        if (enterClk) next_state = CLK_SLEEP;
        else if (enterRam) next_state = RAM_SLEEP;
      end
      CLK_SLEEP: if (wake) next_state = RUN;
      RAM_SLEEP: if (wake) next_state = RUN;
      default: next_state = RUN;
    endcase
    if (coldHit) next_state = RUN;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= RUN;
    else state <= next_state;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleepArmed <= 1'b0;
    end else if (instrDone) begin
      sleepArmed <= sleep_enable_instr;
    end
  end

  // arming holds until a cold start; no instruction or register write releases it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lvArmed <= 1'b0;
    else if (coldHit) lvArmed <= 1'b0;
    else if (instrDone && arm_lowvolt_in_sleep) lvArmed <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sleepFlag <= 1'b0;
    else if (coldHit) sleepFlag <= 1'b0;
    else if (enter) sleepFlag <= 1'b1;
  end

  // slow timer request survives both modes; hardware set beats software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) slowReq <= 1'b0;
    else if (coldHit) slowReq <= 1'b0;
    else if (slowTick || (wrCtrl && pwdata[CT_SLOWSET])) slowReq <= 1'b1;
    else if (wrCtrl && pwdata[CT_SLOWCLR]) slowReq <= 1'b0;
  end

  // ctrl: irq enable and watchdog enable clear on entry, oscillator and pin select kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= RST_CTRL;
    end else if (coldHit) begin
      ctrl <= RST_CTRL;
    end else if (enter) begin
      ctrl[CT_IRQEN] <= 1'b0;
      ctrl[CT_WDEN] <= 1'b0;
    end else if (wrCtrl) begin
      ctrl <= {26'h000_0000, pwdata[5:4], 1'b0, pwdata[2:0]};
    end
  end

  // clock config, prescaler, timer four and serial control nibbles: never touched by sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) keepRegs <= RST_KEEP;
    else if (coldHit) keepRegs <= RST_KEEP;
    else if (wrKeep) keepRegs <= pwdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) timerCtrl <= RST_TCTL;
    else if (coldHit || enter) timerCtrl <= RST_TCTL;
    else if (wrTctl) timerCtrl <= pwdata[19:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core <= 32'h0000_0000;
      core[CO_SP +: 3] <= SP_INIT;
    end else if (coldHit || enter) begin
      core <= 32'h0000_0000;
      core[CO_SP +: 3] <= SP_INIT;
    end else if (wrCore) begin
      core <= {4'h0, pwdata[27:0]};
    end
  end

  // event flags: set wins over write-one-clear, entry and cold reset clear all
  wire [5:0] flagSet = {watchdogEvent2, watchdogEvent1, serialDone, conversionDone,
    extIrqEvent1, extIrqEvent0};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) flags[gi] <= 1'b0;
        else if (coldHit || enter) flags[gi] <= 1'b0;
        else if (flagSet[gi] && running) flags[gi] <= 1'b1;
        else if (wrFlags && pwdata[gi]) flags[gi] <= 1'b0;
      end
    end
  endgenerate

  wire [31:0] statusWord = {26'h000_0000, lvArmed, lvLive, state == RAM_SLEEP,
    state == CLK_SLEEP, slowReq, sleepFlag};
  wire [31:0] readMux =
    paddr == OFS_STATUS ? statusWord :
    paddr == OFS_CTRL ? ctrl :
    paddr == OFS_KEEP ? keepRegs :
    paddr == OFS_TCTL ? {12'h000, timerCtrl} :
    paddr == OFS_CORE ? core :
    paddr == OFS_FLAGS ? {26'h000_0000, flags} : 32'h0000_0000;

  // one access-phase cycle: the answer is prepared during setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= setup && !pwrite ? readMux : 32'h0000_0000;
    end
  end

  // port and function outputs, all from flops
  wire sleepNext = next_state != RUN;
  wire [1:0] counterPinSel = ctrl[CT_PINSEL +: 2];
  wire pinInput = counterPinSel == PINSEL_INPUT;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      startPulse <= 1'b0;
      warmStart <= 1'b0;
      coreInit <= 1'b0;
      peripheralInit <= 1'b0;
      ramOnlyKeep <= 1'b0;
      slowTimerRun <= 1'b1;
      fastTimersRun <= 1'b1;
      displayOn <= 1'b1;
      lowvoltActive <= 1'b0;
      portHold <= 1'b0;
      shared_counter_pin_out <= 1'b0;
      shared_counter_pin_oe <= 1'b0;
    end else begin
      startPulse <= coldHit || wake;
      warmStart <= wake && !coldHit;
      coreInit <= enter || coldHit;
      peripheralInit <= enter || coldHit;
      ramOnlyKeep <= next_state == RAM_SLEEP;
      slowTimerRun <= next_state != RAM_SLEEP;
      fastTimersRun <= !sleepNext;
      displayOn <= next_state != RAM_SLEEP;
      lowvoltActive <= lowvolt_detect_enable_pin && (!sleepNext || lvArmed);
      portHold <= sleepNext;
      shared_counter_pin_out <= sleepNext ? 1'b0 : counterPinDrive;
      shared_counter_pin_oe <= sleepNext ? !pinInput : counterPinDriveEn;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_ENTRY_NEEDS_ENABLE: assert property (
    $rose(portHold) |-> $past(sleepArmed)
  ) else $error("sleep entered without prior enable");
  AST_ENTRY_SETS_FLAG: assert property (
    enter && !coldHit |=> sleepFlag && portHold
  ) else $error("entry did not set sleep flag");
  AST_COLD_CLEARS_FLAG: assert property (
    coldHit |=> !sleepFlag && state == RUN && startPulse && !warmStart
  ) else $error("cold start left sleep flag set");
  AST_WARM_START: assert property (
    wake && !coldHit |=> sleepFlag && warmStart && startPulse
  ) else $error("warm start missing");
  AST_SP_INIT: assert property (
    enter |=> core[CO_SP +: 3] == SP_INIT && core[8:0] == 9'h000
  ) else $error("core context not initialised");
  AST_TCTL_INIT: assert property (
    enter |=> timerCtrl == RST_TCTL
  ) else $error("timer controls not cleared");
  AST_KEEP_HELD: assert property (
    state != RUN && !coldHit && !wrKeep |=> $stable(keepRegs)
  ) else $error("retained registers changed in sleep");
  AST_FLAGS_CLEARED: assert property (
    enter |=> flags == 6'h00 && !ctrl[CT_IRQEN] && !ctrl[CT_WDEN]
  ) else $error("flags survived entry");
  AST_RAM_WAKE_ONLY_EXT: assert property (
    state == RAM_SLEEP && !extWakeup && !coldHit |=> state == RAM_SLEEP
  ) else $error("ram backup left without external wakeup");
  AST_CLK_WAKE_SLOW: assert property (
    state == CLK_SLEEP && slowReq |=> state == RUN
  ) else $error("slow request did not wake");
  AST_DISPLAY_OFF: assert property (
    state == RAM_SLEEP |-> !displayOn && !slowTimerRun
  ) else $error("display on in ram backup");
  AST_PIN_SLEEP: assert property (
    portHold |-> !shared_counter_pin_out && shared_counter_pin_oe != $past(pinInput)
  ) else $error("counter pin wrong in sleep");
  AST_OSC_KEPT: assert property (
    enter && !coldHit |=> $stable(ctrl[CT_OSCSEL])
  ) else $error("oscillator selection changed");

  COV_CLK_SLEEP_WAKE: cover property (enterClk ##[1:50] wakeClk);
  COV_RAM_SLEEP_WAKE: cover property (enterRam ##[1:50] wakeRam);
  COV_NOP_ENTRY: cover property (instrDone && clock_run_sleep_instr && !sleepArmed);
  COV_LV_IN_SLEEP: cover property (state == CLK_SLEEP && lowvoltTrip && lvLive);
endmodule // power_down_wake_control
`default_nettype wire

// File: tb/cpu_side_model.sv
// cpu-side partner: retires instructions and drives the wakeup inputs
`timescale 1ns/10ps
`default_nettype none
module cpu_side_model (
  input wire logic clk,
  output logic instrDone,
  output logic sleep_enable_instr,
  output logic clock_run_sleep_instr,
  output logic ram_keep_sleep_instr,
  output logic arm_lowvolt_in_sleep,
  output logic extWakeup,
  output logic slowTimerUnderflow
);
  initial begin
    {instrDone, extWakeup, slowTimerUnderflow} = 3'h0;
    {arm_lowvolt_in_sleep, ram_keep_sleep_instr, clock_run_sleep_instr, sleep_enable_instr} = 4'h0;
  end
  // code: b3 arm low-volt, b2 ram keep, b1 clock run, b0 enable; gap idles a slow core
  task automatic exec(input logic [3:0] code, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    instrDone <= 1'b1;
    {arm_lowvolt_in_sleep, ram_keep_sleep_instr, clock_run_sleep_instr, sleep_enable_instr} <= code;
    @(posedge clk);
    instrDone <= 1'b0;
    // decode lines are not qualified now, so show garbage rather than the last code
    {arm_lowvolt_in_sleep, ram_keep_sleep_instr, clock_run_sleep_instr, sleep_enable_instr} <= ~code;
  endtask
  task automatic enter(input logic ram, input int gap);
    exec(4'h0, 0);
    exec(4'h1, gap);
    exec(ram ? 4'h4 : 4'h2, gap);
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    extWakeup <= v;
  endtask
  task automatic underflow;
    @(posedge clk);
    slowTimerUnderflow <= 1'b1;
    @(posedge clk);
    slowTimerUnderflow <= 1'b0;
  endtask
endmodule // cpu_side_model
`default_nettype wire

// File: tb/power_down_wake_control_test.sv
// self-checking bench for the power-down and wake controller
`timescale 1ns/10ps
`default_nettype none
module power_down_wake_control_test;
  import pwr_ctl_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic instrDone, sleep_enable_instr, clock_run_sleep_instr, ram_keep_sleep_instr;
  logic arm_lowvolt_in_sleep, extWakeup, slowTimerUnderflow, lowvolt_detect_enable_pin;
  logic resetPinPulse, watchdogReset, lowvoltTrip, counterPinDrive, counterPinDriveEn;
  logic [5:0] ev;
  logic startPulse, warmStart, ramOnlyKeep, slowTimerRun, displayOn, lowvoltActive, portHold;
  logic shared_counter_pin_out, shared_counter_pin_oe;
  logic coreInit, peripheralInit, fastTimersRun;
  int errors, num_checks;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  power_down_wake_control uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .instrDone, .sleep_enable_instr, .clock_run_sleep_instr,
    .ram_keep_sleep_instr, .arm_lowvolt_in_sleep, .extWakeup, .slowTimerUnderflow,
    .resetPinPulse, .watchdogReset, .lowvoltTrip, .lowvolt_detect_enable_pin,
    .extIrqEvent0(ev[0]), .extIrqEvent1(ev[1]), .conversionDone(ev[2]), .serialDone(ev[3]),
    .watchdogEvent1(ev[4]), .watchdogEvent2(ev[5]), .counterPinDrive, .counterPinDriveEn,
    .startPulse, .warmStart, .coreInit, .peripheralInit, .ramOnlyKeep, .slowTimerRun,
    .fastTimersRun, .displayOn, .lowvoltActive, .portHold, .shared_counter_pin_out,
    .shared_counter_pin_oe);
  cpu_side_model cpu (.clk, .instrDone, .sleep_enable_instr, .clock_run_sleep_instr,
    .ram_keep_sleep_instr, .arm_lowvolt_in_sleep, .extWakeup, .slowTimerUnderflow);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state budget here: only the watchdog ends a stuck access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask
  // any cold source set before the call is dropped after one cycle
  task automatic wait_start(input logic expWarm, input logic expSeen);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge clk);
      {resetPinPulse, watchdogReset, lowvoltTrip} <= 3'h0;
      #1;
      seen = (startPulse === 1'b1);
    end
    chk("start", {31'h0, expSeen}, {31'h0, seen});
    if (seen) chk("warm", {31'h0, expWarm}, {31'h0, warmStart});
  endtask
  task automatic s_reset;
    rdchk("status", OFS_STATUS, 32'h0000_0000);
    rdchk("core", OFS_CORE, 32'h0000_0E00);
    chk("display", 1, displayOn);
    cpu.exec(4'h2, 0);
    #1 chk("hold", 0, portHold);
    cpu.exec(4'h1, 0);
    cpu.exec(4'h0, 0);
    cpu.exec(4'h2, 0);
    #1 chk("hold", 0, portHold);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("slverr", 1, err);
    apb(1'b1, OFS_STATUS, 32'h0000_00FF);
    rdchk("status", OFS_STATUS, 32'h0000_0000);
    {counterPinDrive, counterPinDriveEn} <= 2'b00;
    repeat (2) @(posedge clk);
    #1 chk("pin out", 0, shared_counter_pin_out);
    chk("pin oe", 0, shared_counter_pin_oe);
    @(posedge clk) {counterPinDrive, counterPinDriveEn} <= 2'b11;
  endtask
  task automatic s_clock;
    apb(1'b1, OFS_KEEP, 32'hA5A5_5A5A);
    apb(1'b1, OFS_TCTL, 32'h000F_FFFF);
    apb(1'b1, OFS_CORE, 32'h0123_0FFF);
    apb(1'b1, OFS_CTRL, 32'h0000_0007);
    @(posedge clk) ev <= 6'h3F;
    @(posedge clk) ev <= 6'h00;
    rdchk("flags", OFS_FLAGS, 32'h0000_003F);
    chk("pin run", 1, shared_counter_pin_out);
    cpu.enter(1'b0, 2);
    #1 chk("hold", 1, portHold);
    chk("pin oe", 1, shared_counter_pin_oe);
    chk("pin out", 0, shared_counter_pin_out);
    chk("display", 1, displayOn);
    chk("slow run", 1, slowTimerRun);
    chk("fast run", 0, fastTimersRun);
    chk("core init", 1, coreInit);
    chk("periph init", 1, peripheralInit);
    rdchk("status", OFS_STATUS, 32'h0000_0005);
    rdchk("keep", OFS_KEEP, 32'hA5A5_5A5A);
    rdchk("tctl", OFS_TCTL, 32'h0000_0000);
    rdchk("core", OFS_CORE, 32'h0000_0E00);
    rdchk("flags", OFS_FLAGS, 32'h0000_0000);
    rdchk("ctrl", OFS_CTRL, 32'h0000_0004);
    cpu.pin(1'b1);
    wait_start(1'b1, 1'b1);
    chk("fast run", 1, fastTimersRun);
    cpu.pin(1'b0);
    rdchk("status", OFS_STATUS, 32'h0000_0001);
    cpu.enter(1'b0, 0);
    cpu.underflow;
    wait_start(1'b1, 1'b1);
    rdchk("status", OFS_STATUS, 32'h0000_0003);
    apb(1'b1, OFS_CTRL, 32'h0000_0237);
    rdchk("status", OFS_STATUS, 32'h0000_0001);
  endtask
  task automatic s_ram;
    cpu.enter(1'b1, 1);
    #1 chk("ram only", 1, ramOnlyKeep);
    chk("display", 0, displayOn);
    chk("pin oe", 0, shared_counter_pin_oe);
    chk("slow run", 0, slowTimerRun);
    rdchk("status", OFS_STATUS, 32'h0000_0009);
    rdchk("ctrl", OFS_CTRL, 32'h0000_0034);
    cpu.underflow;
    wait_start(1'b0, 1'b0);
    cpu.pin(1'b1);
    wait_start(1'b1, 1'b1);
    cpu.pin(1'b0);
  endtask
  task automatic s_cold;
    for (int i = 0; i < 3; i++) begin
      lowvolt_detect_enable_pin <= 1'b1;
      cpu.exec(4'h8, 0);
      cpu.enter(1'b0, i);
      #1 chk("lv live", 1, lowvoltActive);
      @(posedge clk) {resetPinPulse, watchdogReset, lowvoltTrip} <= 3'(1 << i);
      wait_start(1'b0, 1'b1);
      // detector pin still high and core running, so the detector reads live
      rdchk("status", OFS_STATUS, 32'h0000_0010);
    end
    lowvolt_detect_enable_pin <= 1'b0;
    cpu.exec(4'h8, 0);
    cpu.enter(1'b0, 0);
    #1 chk("lv live", 0, lowvoltActive);
    cpu.pin(1'b1);
    wait_start(1'b1, 1'b1);
    cpu.pin(1'b0);
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {resetPinPulse, watchdogReset, lowvoltTrip, lowvolt_detect_enable_pin} = 4'h0;
    {counterPinDrive, counterPinDriveEn} = 2'b11;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    s_reset;
    s_clock;
    s_ram;
    s_cold;
    end_of_test;
  end
  // whole run needs a few hundred cycles
  initial begin
    #50us;
    errors++;
    end_of_test;
  end
endmodule // power_down_wake_control_test
`default_nettype wire
